// ===== pgs_regs.svh
// register offsets, field positions, reset values and counts of the block
`ifndef PGS_REGS_SVH
`define PGS_REGS_SVH
`define PGS_OFS_OPMODE   8'h00
`define PGS_OFS_LATCH    8'h04
`define PGS_OFS_STATUS   8'h08
`define PGS_OFS_GEAR_EN  8'h0c
`define PGS_OFS_PULSES   8'h10
`define PGS_OFS_TRAVEL   8'h14
`define PGS_OFS_MOTOR    8'h18
`define PGS_OFS_LOAD     8'h1c
`define PGS_OFS_SCALED   8'h20
`define PGS_ARM_BIT      2
`define PGS_GEAR_BIT     0
`define PGS_ST_DET_BIT   0
`define PGS_ST_BUSY_BIT  1
`define PGS_ST_VAL_BIT   2
`define PGS_RST_PULSES   16'h0800
`define PGS_RST_TRAVEL   31'h0000_2710
`define PGS_RST_RATIO    16'h0001
`define PGS_DIV_STEPS    7'h4f
`define PGS_RESP_OKAY    2'h0
`define PGS_RESP_SLVERR  2'h2
`endif

// ===== pgs_pkg.sv
// types shared by the probe latch and gear scaling modules
package pgs_pkg;
	typedef enum logic [2:0] {
		DIV_IDLE = 3'h1,
		DIV_RUN  = 3'h2,
		DIV_DONE = 3'h4
	} pgs_div_state_type;
	typedef logic [78:0] pgs_num_type;
endpackage : pgs_pkg

// ===== pgs_div_if.sv
// request and answer signals between the top and the gear divider
`timescale 1ns/1ps
interface pgs_div_if;
	logic        start;
	logic [31:0] count;
	logic [30:0] travel;
	logic [15:0] pulses;
	logic [15:0] motor;
	logic [15:0] load;
	logic        busy;
	logic        done;
	logic [31:0] quotient;
	modport ctl (output start, count, travel, pulses, motor, load,
		input busy, done, quotient);
	modport eng (input start, count, travel, pulses, motor, load,
		output busy, done, quotient);
endinterface : pgs_div_if

// ===== pgs_gear_div.sv
// gear scaling engine: count * travel * n / (pulses * m), sequential
`timescale 1ns/1ps
module pgs_gear_div
	import pgs_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	pgs_div_if.eng    div
);
`include "pgs_regs.svh"

	pgs_div_state_type state_ff;
	pgs_num_type       num_ff;
	pgs_num_type       num_keep_ff;
	logic [31:0]       den_ff;
	logic [31:0]       rem_ff;
	logic [6:0]        cnt_ff;
	logic              neg_ff;
	logic [32:0]       trial;

	// two's complement negate, used for the operand and for the answer
	function automatic logic [31:0] neg32(input logic [31:0] v);
		neg32 = ~v + 32'h0000_0001;
	endfunction : neg32

	assign trial = {rem_ff, num_ff[78]};

	////////////////////////////////////////////////////////////////////
	// state sequence; one step per bit keeps the datapath small
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= DIV_IDLE;
			cnt_ff   <= 7'h00;
		end else begin
			unique case (state_ff)
				DIV_IDLE: begin
					if (div.start) begin
						state_ff <= DIV_RUN;
						cnt_ff   <= `PGS_DIV_STEPS;
					end
				end
				DIV_RUN: begin
					cnt_ff <= cnt_ff - 7'h01;
					if (cnt_ff == 7'h01) begin
						state_ff <= DIV_DONE;
					end
				end
				DIV_DONE: begin
					state_ff <= DIV_IDLE;
				end
				default: begin
					state_ff <= DIV_IDLE;
				end
			endcase
		end
	end

	// restoring division; the numerator register collects the quotient
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			num_ff      <= '0;
			num_keep_ff <= '0;
			den_ff      <= 32'h0000_0000;
			rem_ff      <= 32'h0000_0000;
			neg_ff      <= 1'b0;
		end else if (state_ff == DIV_IDLE && div.start) begin
			neg_ff <= div.count[31];
			num_ff <= 79'(div.count[31] ? neg32(div.count) : div.count)
				* 79'(div.travel) * 79'(div.load);
			num_keep_ff <= 79'(div.count[31] ? neg32(div.count)
				: div.count) * 79'(div.travel) * 79'(div.load);
			den_ff <= 32'(div.pulses) * 32'(div.motor);
			rem_ff <= 32'h0000_0000;
		end else if (state_ff == DIV_RUN) begin
			if (trial >= {1'b0, den_ff}) begin
				rem_ff <= 32'(trial - {1'b0, den_ff});
				num_ff <= {num_ff[77:0], 1'b1};
			end else begin
				rem_ff <= trial[31:0];
				num_ff <= {num_ff[77:0], 1'b0};
			end
		end
	end

	// answer is truncated to the low word, sign restored afterwards
	assign div.busy     = (state_ff != DIV_IDLE);
	assign div.done     = (state_ff == DIV_DONE);
	assign div.quotient = neg_ff ? neg32(num_ff[31:0]) : num_ff[31:0];

	////////////////////////////////////////////////////////////////////
	a_div_latency: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(state_ff == DIV_IDLE && div.start) |-> ##80 div.done)
		else $error("divider did not finish in 80 cycles");

	a_div_exact: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		div.done |-> (111'(num_ff) * 111'(den_ff) + 111'(rem_ff)
			== 111'(num_keep_ff)) && (rem_ff < den_ff))
		else $error("gear quotient does not match operands");

endmodule : pgs_gear_div

// ===== pgs_top.sv
// probe position latch with electronic gear scaling, axi4-lite slave
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module pgs_top
	import pgs_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_probe_input,
	input  wire logic [31:0] i_position_count,
	input  wire logic        i_axi_awvalid,
	output logic             o_axi_awready,
	input  wire logic [7:0]  i_axi_awaddr,
	input  wire logic        i_axi_wvalid,
	output logic             o_axi_wready,
	input  wire logic [31:0] i_axi_wdata,
	input  wire logic [3:0]  i_axi_wstrb,
	output logic             o_axi_bvalid,
	input  wire logic        i_axi_bready,
	output logic [1:0]       o_axi_bresp,
	input  wire logic        i_axi_arvalid,
	output logic             o_axi_arready,
	input  wire logic [7:0]  i_axi_araddr,
	output logic             o_axi_rvalid,
	input  wire logic        i_axi_rready,
	output logic [31:0]      o_axi_rdata,
	output logic [1:0]       o_axi_rresp
);
`include "pgs_regs.svh"

	pgs_div_if div ();

	logic        probe_s1_ff;
	logic        probe_s2_ff;
	logic        probe_s3_ff;
	logic        probe_rise;
	logic        capture;
	logic [31:0] opmode_ff;
	logic        gear_en_ff;
	logic [15:0] pulses_ff;
	logic [30:0] travel_ff;
	logic [15:0] motor_ff;
	logic [15:0] load_ff;
	logic [31:0] latched_ff;
	logic [31:0] scaled_ff;
	logic        detected_ff;
	logic        scaled_ok_ff;
	logic        start_pend_ff;
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        wr_fire;
	logic [31:0] wr_val;
	logic        wr_bad;
	logic        rd_fire;

	// byte-lane merge of write data into the current register value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		merge = res;
	endfunction : merge

	// current value of a register, zero for unmapped offsets
	function automatic logic [31:0] reg_val(input logic [7:0] ofs);
		unique case (ofs)
			`PGS_OFS_OPMODE:  reg_val = opmode_ff;
			`PGS_OFS_LATCH:   reg_val = latched_ff;
			`PGS_OFS_STATUS:  reg_val = {29'h0, scaled_ok_ff,
				div.busy, detected_ff};
			`PGS_OFS_GEAR_EN: reg_val = {31'h0, gear_en_ff};
			`PGS_OFS_PULSES:  reg_val = {16'h0, pulses_ff};
			`PGS_OFS_TRAVEL:  reg_val = {1'b0, travel_ff};
			`PGS_OFS_MOTOR:   reg_val = {16'h0, motor_ff};
			`PGS_OFS_LOAD:    reg_val = {16'h0, load_ff};
			`PGS_OFS_SCALED:  reg_val = scaled_ff;
			default:          reg_val = 32'h0000_0000;
		endcase
	endfunction : reg_val

	pgs_gear_div u_div (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.div       (div)
	);

	////////////////////////////////////////////////////////////////////
	// probe pin synchroniser; third stage only for edge detection
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			probe_s1_ff <= 1'b0;
			probe_s2_ff <= 1'b0;
			probe_s3_ff <= 1'b0;
		end else begin
			probe_s1_ff <= i_probe_input;
			probe_s2_ff <= probe_s1_ff;
			probe_s3_ff <= probe_s2_ff;
		end
	end

	// only the dedicated probe pin can trigger, gated by the arm bit
	assign probe_rise = probe_s2_ff & ~probe_s3_ff;
	assign capture    = probe_rise & opmode_ff[`PGS_ARM_BIT];

	// position capture; the counter is on this clock, no sync needed
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latched_ff <= 32'h0000_0000;
		end else if (capture) begin
			latched_ff <= i_position_count;
		end
	end

	// detected flag: a capture in the clearing cycle wins
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			detected_ff <= 1'b0;
		end else if (capture) begin
			detected_ff <= 1'b1;
		end else if (wr_fire && !wr_bad && awaddr_ff == `PGS_OFS_OPMODE
			&& !wr_val[`PGS_ARM_BIT]) begin
			detected_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// gear scaling; a capture during a division is queued, not lost
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_pend_ff <= 1'b0;
		end else if (capture && gear_en_ff) begin
			start_pend_ff <= 1'b1;
		end else if (!div.busy) begin
			start_pend_ff <= 1'b0;
		end
	end

	assign div.start  = start_pend_ff & ~div.busy;
	assign div.count  = latched_ff;
	assign div.travel = travel_ff;
	assign div.pulses = pulses_ff;
	assign div.motor  = motor_ff;
	assign div.load   = load_ff;

	// raw copy when the gear is off, divider answer when it is on
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scaled_ff    <= 32'h0000_0000;
			scaled_ok_ff <= 1'b0;
		end else if (capture && !gear_en_ff) begin
			scaled_ff    <= i_position_count;
			scaled_ok_ff <= 1'b1;
		end else if (capture) begin
			scaled_ok_ff <= 1'b0;
		end else if (div.done && !start_pend_ff) begin
			scaled_ff    <= div.quotient;
			scaled_ok_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	assign wr_fire = aw_held_ff & w_held_ff & ~o_axi_bvalid;
	assign wr_val  = merge(reg_val(awaddr_ff), wdata_ff, wstrb_ff);

	// out-of-range settings and read-only offsets are refused
	always_comb begin
		unique case (awaddr_ff)
			`PGS_OFS_OPMODE, `PGS_OFS_GEAR_EN: wr_bad = 1'b0;
			`PGS_OFS_PULSES, `PGS_OFS_MOTOR,
			`PGS_OFS_LOAD: wr_bad = (wr_val[31:16] != 16'h0)
				|| (wr_val[15:0] == 16'h0);
			`PGS_OFS_TRAVEL: wr_bad = wr_val[31]
				|| (wr_val[30:0] == 31'h0);
			default: wr_bad = 1'b1;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			awaddr_ff     <= 8'h00;
			wdata_ff      <= 32'h0000_0000;
			wstrb_ff      <= 4'h0;
			o_axi_awready <= 1'b0;
			o_axi_wready  <= 1'b0;
		end else begin
			o_axi_awready <= ~aw_held_ff & ~o_axi_awready;
			o_axi_wready  <= ~w_held_ff & ~o_axi_wready;
			if (i_axi_awvalid && o_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= {i_axi_awaddr[7:2], 2'h0};
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (i_axi_wvalid && o_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= i_axi_wdata;
				wstrb_ff  <= i_axi_wstrb;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// write response follows both halves
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_axi_bvalid <= 1'b0;
			o_axi_bresp  <= `PGS_RESP_OKAY;
		end else if (wr_fire) begin
			o_axi_bvalid <= 1'b1;
			o_axi_bresp  <= wr_bad ? `PGS_RESP_SLVERR : `PGS_RESP_OKAY;
		end else if (i_axi_bready) begin
			o_axi_bvalid <= 1'b0;
		end
	end

	// software settings; defaults are the usual gear parameters
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			opmode_ff  <= 32'h0000_0000;
			gear_en_ff <= 1'b0;
			pulses_ff  <= `PGS_RST_PULSES;
			travel_ff  <= `PGS_RST_TRAVEL;
			motor_ff   <= `PGS_RST_RATIO;
			load_ff    <= `PGS_RST_RATIO;
		end else if (wr_fire && !wr_bad) begin
			unique case (awaddr_ff)
				`PGS_OFS_OPMODE:  opmode_ff  <= wr_val;
				`PGS_OFS_GEAR_EN: gear_en_ff <= wr_val[`PGS_GEAR_BIT];
				`PGS_OFS_PULSES:  pulses_ff  <= wr_val[15:0];
				`PGS_OFS_TRAVEL:  travel_ff  <= wr_val[30:0];
				`PGS_OFS_MOTOR:   motor_ff   <= wr_val[15:0];
				`PGS_OFS_LOAD:    load_ff    <= wr_val[15:0];
				default:          opmode_ff  <= opmode_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// read channel: one cycle to accept, data the next edge
	assign rd_fire = i_axi_arvalid & o_axi_arready;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid  <= 1'b0;
			o_axi_rdata   <= 32'h0000_0000;
			o_axi_rresp   <= `PGS_RESP_OKAY;
		end else begin
			o_axi_arready <= ~o_axi_rvalid & ~o_axi_arready & ~rd_fire;
			if (rd_fire) begin
				o_axi_rvalid <= 1'b1;
				o_axi_rdata  <= reg_val({i_axi_araddr[7:2], 2'h0});
				o_axi_rresp  <= ({i_axi_araddr[7:2], 2'h0}
					> `PGS_OFS_SCALED) ? `PGS_RESP_SLVERR : `PGS_RESP_OKAY;
			end else if (i_axi_rready) begin
				o_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence s_gear_capture;
		capture && gear_en_ff && !div.busy && !start_pend_ff;
	endsequence

	sequence s_gear_answer;
		##[1:3] div.busy ##[78:82] (div.done && !start_pend_ff);
	endsequence

	a_probe_capture: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		capture |=> latched_ff == $past(i_position_count))
		else $error("latch missed the probe position");

	a_probe_source: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		capture |-> $past(i_probe_input, 2) && !$past(i_probe_input, 3))
		else $error("capture without a probe pin rising edge");

	a_arm_gating: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		!opmode_ff[`PGS_ARM_BIT] |=> $stable(latched_ff))
		else $error("latch changed while not armed");

	a_latch_readback: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(rd_fire && i_axi_araddr == `PGS_OFS_LATCH)
		|=> o_axi_rvalid && o_axi_rdata == $past(latched_ff))
		else $error("latched position word read back wrong");

	a_travel_range: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		travel_ff != 31'h0)
		else $error("travel per revolution left its range");

	a_ratio_range: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		motor_ff != 16'h0 && load_ff != 16'h0 && pulses_ff != 16'h0)
		else $error("gear ratio setting left its range");

	a_gear_result: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		s_gear_capture |-> s_gear_answer ##1 scaled_ok_ff)
		else $error("scaled position not produced in time");

	a_bresp_hold: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid
			&& $stable(o_axi_bresp))
		else $error("write response dropped before bready");

endmodule : pgs_top

// ===== pgs_probe_model.sv
// far-side model: probe pin and encoder position counter
`timescale 1ns/1ps
module pgs_probe_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_fire,
	input  wire logic        i_load,
	input  wire logic [31:0] i_load_val,
	output logic             o_probe_input,
	output logic [31:0]      o_position_count,
	output logic             o_busy
);
	logic [3:0] step_ff;

	// one probe pulse: 4 clocks high then 5 low, so the synchroniser sees both
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			step_ff <= 4'h0;
		end else if (step_ff != 4'h0) begin
			step_ff <= (step_ff == 4'h9) ? 4'h0 : step_ff + 4'h1;
		end else if (i_fire) begin
			step_ff <= 4'h1;
		end
	end
	assign o_probe_input = (step_ff >= 4'h1) && (step_ff <= 4'h4);
	assign o_busy        = (step_ff != 4'h0);

	// position holds still unless loaded, so the captured value is known
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_position_count <= 32'h0000_0000;
		end else if (i_load) begin
			o_position_count <= i_load_val;
		end
	end
endmodule : pgs_probe_model

// ===== pgs_tb_top.sv
// self-checking bench of the probe latch and gear scaling block
`timescale 1ns/1ps
`include "pgs_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pgs_tb_top;
	logic        i_sys_clk = 1'b0;
	logic        i_rst_n   = 1'b0;
	logic        fire = 1'b0, load = 1'b0;
	logic [31:0] load_val = 32'h0;
	logic        probe, busy;
	logic [31:0] pos;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          err_count = 0;
	int          tests_run = 0;
	logic [31:0] d;
	logic [1:0]  r;

	always #5 i_sys_clk = ~i_sys_clk;

	pgs_probe_model u_pgs_probe_model (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_fire(fire), .i_load(load),
		.i_load_val(load_val), .o_probe_input(probe),
		.o_position_count(pos), .o_busy(busy));

	pgs_top u_pgs_top (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_probe_input(probe), .i_position_count(pos),
		.i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid),
		.o_axi_wready(wready), .i_axi_wdata(wdata),
		.i_axi_wstrb(wstrb), .o_axi_bvalid(bvalid),
		.i_axi_bready(bready), .o_axi_bresp(bresp),
		.i_axi_arvalid(arvalid), .o_axi_arready(arready),
		.i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
		.i_axi_rready(rready), .o_axi_rdata(rdata),
		.o_axi_rresp(rresp));

	////////////////////////////////////////////////////////////////////////
	// verdict and end of run, also reached by any exhausted wait
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	task automatic hung(input string what);
		err_count++;
		$display("MISMATCH %s expected answer seen none", what);
		complete_run();
	endtask : hung

	// axi write: both halves offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		bit aw_p, w_p, fin;
		aw_p = 1;
		w_p  = 1;
		fin  = 0;
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= v;
		bready  <= 1'b1;
		for (int n = 0; n < 100 && !fin; n++) begin
			@(posedge i_sys_clk);
			if (aw_p && awready) begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 0;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				rs  = bresp;
				fin = 1;
				bready <= 1'b0;
			end
		end
		if (!fin) hung("write response");
		@(posedge i_sys_clk);
	endtask : axi_wr

	// axi read: address held until taken, rready held until rvalid
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		bit fin;
		fin = 0;
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (int n = 0; n < 100 && !fin; n++) begin
			@(posedge i_sys_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				v   = rdata;
				rs  = rresp;
				fin = 1;
				rready <= 1'b0;
			end
		end
		if (!fin) hung("read data");
		@(posedge i_sys_clk);
	endtask : axi_rd

	// load a position into the model, then fire one probe pulse
	task automatic probe_at(input logic [31:0] p);
		load     <= 1'b1;
		load_val <= p;
		@(posedge i_sys_clk);
		load <= 1'b0;
		fire <= 1'b1;
		@(posedge i_sys_clk);
		fire <= 1'b0;
		// busy read at the firing edge is still the old idle value
		@(posedge i_sys_clk);
		for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge i_sys_clk);
		if (busy !== 1'b0) hung("probe pulse");
		repeat (3) @(posedge i_sys_clk);
	endtask : probe_at

	////////////////////////////////////////////////////////////////////////
	// gear parameters come out of reset at their defaults
	task automatic t_defaults();
		axi_rd(`PGS_OFS_PULSES, d, r);
		`CHK("pulses reset", 32'h0000_0800, d)
		axi_rd(`PGS_OFS_TRAVEL, d, r);
		`CHK("travel reset", 32'h0000_2710, d)
		axi_rd(`PGS_OFS_MOTOR, d, r);
		`CHK("motor reset", 32'h0000_0001, d)
		axi_rd(`PGS_OFS_LOAD, d, r);
		`CHK("load reset", 32'h0000_0001, d)
		$display("test defaults done");
	endtask : t_defaults

	// armed capture, then no capture without probe or without arm
	task automatic t_capture();
		axi_wr(`PGS_OFS_OPMODE, 32'h0000_0004, r);
		probe_at(32'hcafe_0123);
		axi_rd(`PGS_OFS_LATCH, d, r);
		`CHK("latched position", 32'hcafe_0123, d)
		axi_rd(`PGS_OFS_STATUS, d, r);
		`CHK("detected flag", 1'b1, d[`PGS_ST_DET_BIT])
		axi_rd(`PGS_OFS_SCALED, d, r);
		`CHK("raw scaled", 32'hcafe_0123, d)
		load     <= 1'b1;
		load_val <= 32'h0bad_0bad;
		@(posedge i_sys_clk);
		load <= 1'b0;
		repeat (6) @(posedge i_sys_clk);
		axi_rd(`PGS_OFS_LATCH, d, r);
		`CHK("no probe no capture", 32'hcafe_0123, d)
		axi_wr(`PGS_OFS_OPMODE, 32'h0000_0000, r);
		probe_at(32'h1357_9bdf);
		axi_rd(`PGS_OFS_LATCH, d, r);
		`CHK("disarmed latch", 32'hcafe_0123, d)
		axi_rd(`PGS_OFS_STATUS, d, r);
		`CHK("disarmed flag", 1'b0, d[`PGS_ST_DET_BIT])
		$display("test capture done");
	endtask : t_capture

	// parameter range limits and refused accesses
	task automatic t_ranges();
		axi_wr(`PGS_OFS_PULSES, 32'h0000_0000, r);
		`CHK("pulses zero refused", `PGS_RESP_SLVERR, r)
		axi_wr(`PGS_OFS_TRAVEL, 32'h8000_0000, r);
		`CHK("travel over refused", `PGS_RESP_SLVERR, r)
		axi_wr(`PGS_OFS_TRAVEL, 32'h7fff_ffff, r);
		`CHK("travel max taken", `PGS_RESP_OKAY, r)
		axi_wr(`PGS_OFS_MOTOR, 32'h0001_0000, r);
		`CHK("motor over refused", `PGS_RESP_SLVERR, r)
		axi_wr(`PGS_OFS_LOAD, 32'h0000_ffff, r);
		axi_rd(`PGS_OFS_LOAD, d, r);
		`CHK("load max kept", 32'h0000_ffff, d)
		wstrb <= 4'h1;
		axi_wr(`PGS_OFS_LOAD, 32'h0000_0012, r);
		wstrb <= 4'hf;
		axi_rd(`PGS_OFS_LOAD, d, r);
		`CHK("load byte merge", 32'h0000_ff12, d)
		axi_wr(`PGS_OFS_LATCH, 32'h1111_1111, r);
		`CHK("latch read only", `PGS_RESP_SLVERR, r)
		axi_rd(8'h24, d, r);
		`CHK("unmapped resp", `PGS_RESP_SLVERR, r)
		$display("test ranges done");
	endtask : t_ranges

	// capture p with the gear on, then wait for and compare the answer
	task automatic gear_at(input logic [31:0] p, input logic [31:0] e);
		probe_at(p);
		axi_rd(`PGS_OFS_STATUS, d, r);
		`CHK("divider busy", 1'b1, d[`PGS_ST_BUSY_BIT])
		for (int n = 0; n < 60 && d[`PGS_ST_VAL_BIT] !== 1'b1; n++) begin
			axi_rd(`PGS_OFS_STATUS, d, r);
		end
		if (d[`PGS_ST_VAL_BIT] !== 1'b1) hung("scaled valid");
		axi_rd(`PGS_OFS_SCALED, d, r);
		`CHK("scaled position", e, d)
	endtask : gear_at

	// 14336 counts * 6000 * 5 / (2048 * 7) gives 30000 reference units;
	// a negative count keeps its sign through the scaling
	task automatic t_gear();
		axi_wr(`PGS_OFS_PULSES, 32'h0000_0800, r);
		axi_wr(`PGS_OFS_TRAVEL, 32'h0000_1770, r);
		axi_wr(`PGS_OFS_MOTOR, 32'h0000_0007, r);
		axi_wr(`PGS_OFS_LOAD, 32'h0000_0005, r);
		axi_wr(`PGS_OFS_GEAR_EN, 32'h0000_0001, r);
		axi_wr(`PGS_OFS_OPMODE, 32'h0000_0004, r);
		gear_at(32'h0000_3800, 32'h0000_7530);
		gear_at(32'hffff_c800, 32'hffff_8ad0);
		$display("test gear done");
	endtask : t_gear

	////////////////////////////////////////////////////////////////////////
	// main sequence: reset for 10 clocks, then every scenario in turn
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		@(posedge i_sys_clk);
		t_defaults();
		t_capture();
		t_ranges();
		t_gear();
		complete_run();
	end
endmodule : pgs_tb_top
